/* rtl/ctm_pkg.sv */
// package for the compact timer control block
package ctm_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTM_ADDR_AL = 12'h000;
  localparam logic [11:0] CTM_ADDR_AH = 12'h004;
  localparam logic [11:0] CTM_ADDR_C0 = 12'h008;
  localparam logic [11:0] CTM_ADDR_C1 = 12'h00C;
  localparam logic [11:0] CTM_ADDR_CNT = 12'h010;
  localparam logic [11:0] CTM_ADDR_STAT = 12'h014;
  localparam logic [7:0] CTM_RST_BYTE = 8'h00;
  localparam int CTM_CNT_W = 10;
  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CTM_CK_SYS4 = 3'h0;
  localparam logic [2:0] CTM_CK_SYS = 3'h1;
  localparam logic [2:0] CTM_CK_H16 = 3'h2;
  localparam logic [2:0] CTM_CK_H64 = 3'h3;
  localparam logic [2:0] CTM_CK_TBC = 3'h4;
  localparam logic [2:0] CTM_CK_RSV = 3'h5;
  localparam logic [2:0] CTM_CK_EXTR = 3'h6;
  localparam logic [2:0] CTM_CK_EXTF = 3'h7;
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;
  localparam logic [1:0] CTM_IO_NONE = 2'h0;
  localparam logic [1:0] CTM_IO_LOW = 2'h1;
  localparam logic [1:0] CTM_IO_HIGH = 2'h2;
  localparam logic [1:0] CTM_IO_TOG = 2'h3;
  localparam logic [2:0] CTM_DIV4_M = 3'h3;
  localparam logic [5:0] CTM_DIV16_M = 6'h0F;
  localparam logic [5:0] CTM_DIV64_M = 6'h3F;
  // ---------------------------------------------------------------
  // control register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pause_control;
    logic [2:0] clock_select;
    logic timer_on;
    logic [2:0] period_code;
  } ctm_c0_t;
  typedef struct packed {
    logic [1:0] op_mode_select;
    logic [1:0] pin_action;
    logic output_initial_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_select;
  } ctm_c1_t;
  typedef struct packed {
    logic pin0;
    logic pin1;
  } ctm_pin_en_t;
  typedef enum logic [2:0] {
    CTM_ST_OFF = 3'b001,
    CTM_ST_RUN = 3'b010,
    CTM_ST_HOLD = 3'b100
  } ctm_state_t;
endpackage

/* rtl/ctm_timer.sv */
// compact 10-bit timer: control, comparators, output pins, apb slave
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int CNT_W = CTM_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic time_base_tick,
  input wire logic external_count_pin,
  input wire ctm_pkg::ctm_pin_en_t pin_enable,
  output logic timer_output_pin_0,
  output logic timer_output_pin_1,
  output logic match_a_flag,
  output logic match_p_flag
);
  import ctm_pkg::*;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [7:0] a_low;
  logic [1:0] a_high;
  logic [7:0] low_buf;
  ctm_c0_t c0;
  ctm_c1_t c1;
  logic [CNT_W-1:0] count;
  logic out_level;
  ctm_state_t state;
  logic acc, wr, rd, hit;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit = (paddr == CTM_ADDR_AL) | (paddr == CTM_ADDR_AH) | (paddr == CTM_ADDR_C0)
             | (paddr == CTM_ADDR_C1) | (paddr == CTM_ADDR_CNT) | (paddr == CTM_ADDR_STAT);
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  // low byte reads come from the buffer, not the live value
  assign prdata = (paddr == CTM_ADDR_AL) ? {24'h000000, low_buf} :
                  (paddr == CTM_ADDR_AH) ? {30'h00000000, a_high} :
                  (paddr == CTM_ADDR_C0) ? {24'h000000, c0} :
                  (paddr == CTM_ADDR_C1) ? {24'h000000, c1} :
                  (paddr == CTM_ADDR_CNT) ? {{(32-CNT_W){1'b0}}, count} :
                  (paddr == CTM_ADDR_STAT) ? {29'h00000000, out_level, match_p_flag,
                                              match_a_flag} : 32'h00000000;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] match_a_value;
  assign match_a_value = CNT_W'({a_high, a_low});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buf <= CTM_RST_BYTE;
      a_low <= CTM_RST_BYTE;
      a_high <= 2'h0;
    end else if (wr && paddr == CTM_ADDR_AL) begin
      low_buf <= pwdata[7:0];
    end else if (wr && paddr == CTM_ADDR_AH) begin
      a_high <= pwdata[1:0];
      a_low <= low_buf;
    end else if (rd && paddr == CTM_ADDR_AH) begin
      low_buf <= a_low;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0 <= ctm_c0_t'(CTM_RST_BYTE);
      c1 <= ctm_c1_t'(CTM_RST_BYTE);
    end else begin
      if (wr && paddr == CTM_ADDR_C0) c0 <= ctm_c0_t'(pwdata[7:0]);
      if (wr && paddr == CTM_ADDR_C1) c1 <= ctm_c1_t'(pwdata[7:0]);
    end
  end

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  logic [2:0] div4;
  logic [5:0] div_h;
  logic ext_s1, ext_s2, ext_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4 <= 3'h0;
      div_h <= 6'h00;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      div4 <= (div4 == CTM_DIV4_M) ? 3'h0 : div4 + 3'h1;
      if (high_clock_tick) div_h <= div_h + 6'h01;
      ext_s1 <= external_count_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end
  logic ext_rise, ext_fall, tick;
  assign ext_rise = ext_s2 & ~ext_prev;
  assign ext_fall = ~ext_s2 & ext_prev;
  assign tick = (c0.clock_select == CTM_CK_SYS4) ? (div4 == CTM_DIV4_M) :
                (c0.clock_select == CTM_CK_SYS) ? 1'b1 :
                (c0.clock_select == CTM_CK_H16) ?
                  (high_clock_tick && (div_h[3:0] == CTM_DIV16_M[3:0])) :
                (c0.clock_select == CTM_CK_H64) ?
                  (high_clock_tick && (div_h == CTM_DIV64_M)) :
                (c0.clock_select == CTM_CK_TBC) ? time_base_tick :
                (c0.clock_select == CTM_CK_EXTR) ? ext_rise :
                (c0.clock_select == CTM_CK_EXTF) ? ext_fall : 1'b0;

  // ---------------------------------------------------------------
  // run state: off, running, paused
  // ---------------------------------------------------------------
  logic on_d, on_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_d <= 1'b0;
    else on_d <= c0.timer_on;
  end
  assign on_rise = c0.timer_on & ~on_d;
  ctm_state_t next_state;
  always_comb begin
    case (state)
      CTM_ST_OFF: next_state = c0.timer_on ? (c0.pause_control ? CTM_ST_HOLD : CTM_ST_RUN)
                                           : CTM_ST_OFF;
      CTM_ST_RUN: next_state = !c0.timer_on ? CTM_ST_OFF :
                               c0.pause_control ? CTM_ST_HOLD : CTM_ST_RUN;
      CTM_ST_HOLD: next_state = !c0.timer_on ? CTM_ST_OFF :
                                c0.pause_control ? CTM_ST_HOLD : CTM_ST_RUN;
      default: next_state = CTM_ST_OFF;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= CTM_ST_OFF;
    else state <= next_state;
  end

  // ---------------------------------------------------------------
  // comparators and counter
  // ---------------------------------------------------------------
  logic is_pwm, is_cmp, counting, cmp_a, cmp_p, ovf, clr_a, clr_p;
  assign is_pwm = (c1.op_mode_select == CTM_MODE_PWM);
  assign is_cmp = (c1.op_mode_select == CTM_MODE_CMP);
  assign counting = (state == CTM_ST_RUN) & c0.timer_on & ~c0.pause_control & tick;
  // coarse compare on top three bits at bit-7 boundary
  assign cmp_p = counting && (c0.period_code != 3'h0) && (count[6:0] == 7'h7F)
                 && (count[CNT_W-1:CNT_W-3] == c0.period_code - 3'h1);
  // full-width compare, a would-be next count hit
  assign cmp_a = counting && (match_a_value != '0)
                 && (count + CNT_W'(1) == match_a_value);
  assign ovf = counting && (count == {CNT_W{1'b1}});
  // pwm period source picked by swap bit
  // clear source chosen by clear select
  assign clr_a = is_pwm ? c1.period_duty_swap : c1.clear_select;
  assign clr_p = is_pwm ? ~c1.period_duty_swap : ~c1.clear_select;
  logic wrap;
  assign wrap = (clr_a & cmp_a) | (clr_p & cmp_p) | ovf;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count <= '0;
    else if (on_rise) count <= '0;
    else if (wrap) count <= '0;
    else if (counting) count <= count + CNT_W'(1);
  end

  // sticky match flags, set wins over software clear
  logic clr_fa, clr_fp;
  assign clr_fa = wr && (paddr == CTM_ADDR_STAT) && pwdata[0];
  assign clr_fp = wr && (paddr == CTM_ADDR_STAT) && pwdata[1];
  logic set_fa, set_fp;
  assign set_fa = cmp_a;
  assign set_fp = cmp_p & (is_pwm | ~c1.clear_select);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= set_fa | (match_a_flag & ~clr_fa);
      match_p_flag <= set_fp | (match_p_flag & ~clr_fp);
    end
  end

  // ---------------------------------------------------------------
  // output waveform
  // ---------------------------------------------------------------
  // period boundary and duty threshold in counter units
  logic [CNT_W:0] per_p, duty_v, per_v;
  logic pwm_act;
  assign per_p = (c0.period_code == 3'h0) ? (CNT_W+1)'(1) << CNT_W
                 : (CNT_W+1)'({c0.period_code, 7'h00});
  assign per_v = c1.period_duty_swap ? (CNT_W+1)'(match_a_value) : per_p;
  assign duty_v = c1.period_duty_swap ? per_p : (CNT_W+1)'(match_a_value);
  // duty at or above period stays active
  assign pwm_act = (duty_v >= per_v) || ((CNT_W+1)'(count) < duty_v);
  // same level as initial is a no-op by construction of hold
  logic next_level;
  always_comb begin
    next_level = out_level;
    case (c1.pin_action)
      CTM_IO_LOW: next_level = 1'b0;
      CTM_IO_HIGH: next_level = 1'b1;
      CTM_IO_TOG: next_level = ~out_level;
      default: next_level = out_level;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) out_level <= 1'b0;
    else if (is_cmp && on_rise) out_level <= c1.output_initial_level;
    else if (is_cmp && cmp_a) out_level <= next_level;
  end
  // pwm pin behaviour; active level polarity
  logic pwm_pin, raw_out, next_pin;
  assign pwm_pin = (c1.pin_action == CTM_IO_NONE) ? ~c1.output_initial_level :
                   (c1.pin_action == CTM_IO_LOW) ? c1.output_initial_level :
                   (c1.pin_action == CTM_IO_HIGH) ? (pwm_act ~^ c1.output_initial_level)
                   : ~c1.output_initial_level;
  // mode steers pin source; timer and undefined drive low
  assign raw_out = is_cmp ? out_level : is_pwm ? pwm_pin : 1'b0;
  // invert stage, skipped in timer mode
  assign next_pin = (is_cmp | is_pwm) ? (raw_out ^ c1.output_invert) : 1'b0;
  // pin enables come from outside pin-share control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin_0 <= 1'b0;
      timer_output_pin_1 <= 1'b0;
    end else begin
      timer_output_pin_0 <= pin_enable.pin0 & next_pin;
      timer_output_pin_1 <= pin_enable.pin1 & next_pin;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pause_hold_a: assert property (c0.pause_control && $past(c0.pause_control) |=>
    $stable(count) || $past(on_rise)) else $error("count moved while paused");
  rsv_clock_a: assert property ((c0.clock_select == CTM_CK_RSV) |-> !counting)
    else $error("count tick on reserved clock");
  on_rise_a: assert property (on_rise |=> count == '0)
    else $error("counter not cleared on enable");
  off_hold_a: assert property (!c0.timer_on && !on_rise |=> $stable(count))
    else $error("count moved while off");
  init_level_a: assert property (is_cmp && on_rise |=>
    out_level == $past(c1.output_initial_level)) else $error("initial level not set");
  zero_period_a: assert property ((c0.period_code == 3'h0) |-> !cmp_p)
    else $error("p match with zero code");
  pflag_clr_a: assert property (!is_pwm && c1.clear_select && !match_p_flag
    |=> !match_p_flag) else $error("p flag set with clear select");
  toggle_a: assert property (is_cmp && cmp_a && !on_rise
    && c1.pin_action == CTM_IO_TOG |=> out_level != $past(out_level))
    else $error("toggle missing");
  pins_same_a: assert property (pin_enable.pin0 && pin_enable.pin1
    |=> timer_output_pin_0 == timer_output_pin_1) else $error("pins differ");
  hw_write_a: assert property (wr && paddr == CTM_ADDR_AH |=>
    a_low == $past(low_buf)) else $error("low byte not copied");
  run_cv: cover property (on_rise ##[1:20] counting);
  amatch_cv: cover property (cmp_a && is_cmp);
  pwm_cv: cover property (is_pwm && cmp_p);
endmodule // ctm_timer

/* sim/compact_timer_module_control_test.sv */
// self-checking testbench for the compact timer control block
`timescale 1ns/1ps
module compact_timer_module_control_test;
  import ctm_pkg::*;
  // ---------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, last_err;
  logic high_clock_tick = 1'b0;
  logic time_base_tick = 1'b0;
  logic external_count_pin = 1'b0;
  ctm_pin_en_t pin_enable = 2'b11;
  logic timer_output_pin_0, timer_output_pin_1, match_a_flag, match_p_flag;
  logic [7:0] cyc = 8'h00;
  int err_count = 0;
  int n_compared = 0;

  ctm_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_clock_tick(high_clock_tick), .time_base_tick(time_base_tick),
    .external_count_pin(external_count_pin), .pin_enable(pin_enable),
    .timer_output_pin_0(timer_output_pin_0), .timer_output_pin_1(timer_output_pin_1),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

  // 125 MHz clock
  initial begin
    forever #4 pclk = ~pclk;
  end

  // tick sources: internal ticks every other cycle, count pin period 16 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 8'h01;
    high_clock_tick <= ~cyc[0];
    time_base_tick <= ~cyc[0];
    external_count_pin <= cyc[3];
  end

  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      err_count++;
    end
  endtask

  // range compare; an unknown value never lands inside the range
  task automatic rng(input string what, input int lo, input int hi, input logic [31:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("[ERR] %s expected %0d..%0d seen %0h", what, lo, hi, got);
      err_count++;
    end
  endtask

  task automatic give_up(input string what);
    $display("[ERR] %s expected event seen timeout", what);
    err_count++;
    close_out();
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) give_up("pready");
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 8'h00, q);
  endtask

  task automatic wait_flag(input logic sel_p, input int lim, output int n);
    n = 0;
    while (((sel_p ? match_p_flag : match_a_flag) !== 1'b1) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) give_up("match flag");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [11:0] ad[4] = '{CTM_ADDR_AL, CTM_ADDR_AH, CTM_ADDR_C0, CTM_ADDR_C1};
    logic [31:0] q;
    foreach (ad[i]) begin
      rd(ad[i], q);
      chk("register reset value", 32'h0, q);
    end
    wr(CTM_ADDR_C1, 8'h5A);
    rd(CTM_ADDR_C1, q);
    chk("control 1 readback", 32'h5A, q);
    rd(12'h018, q);
    chk("unmapped read data", 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, last_err});
    wr(CTM_ADDR_AL, 8'hA5);
    wr(CTM_ADDR_AH, 8'hFE);
    rd(CTM_ADDR_AH, q);
    chk("match high bits", 32'h2, q);
    rd(CTM_ADDR_AL, q);
    chk("match low via buffer", 32'hA5, q);
    // low write alone must not reach the live low byte
    wr(CTM_ADDR_AL, 8'h3C);
    rd(CTM_ADDR_AH, q);
    rd(CTM_ADDR_AL, q);
    chk("low byte after lone write", 32'hA5, q);
    wr(CTM_ADDR_C1, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_clock;
    int exp[8] = '{100, 400, 12, 3, 200, 0, 25, 25};
    logic [31:0] q;
    wr(CTM_ADDR_C1, 8'hC0);
    for (int k = 0; k < 8; k++) begin
      wr(CTM_ADDR_C0, {1'b0, 3'(k), 4'h0});
      wr(CTM_ADDR_C0, {1'b0, 3'(k), 4'h8});
      repeat (400) @(posedge pclk);
      wr(CTM_ADDR_C0, {1'b0, 3'(k), 4'h0});
      rd(CTM_ADDR_CNT, q);
      rng("count per clock select", (exp[k] > 3) ? exp[k] - 3 : 0, (exp[k] > 0) ? exp[k] + 6 : 0, q);
    end
    $display("test clock select done");
  endtask

  task automatic t_pause;
    logic [31:0] a, b, c;
    wr(CTM_ADDR_C0, 8'h10);
    wr(CTM_ADDR_C0, 8'h18);
    repeat (50) @(posedge pclk);
    wr(CTM_ADDR_C0, 8'h98);
    rd(CTM_ADDR_CNT, a);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT, b);
    chk("count while paused", a, b);
    wr(CTM_ADDR_C0, 8'h18);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT, c);
    rng("count after resume", int'(b) + 20, int'(b) + 30, c);
    wr(CTM_ADDR_C0, 8'h10);
    rd(CTM_ADDR_CNT, a);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT, b);
    chk("count kept when off", a, b);
    wr(CTM_ADDR_C0, 8'h58);
    rd(CTM_ADDR_CNT, a);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT, b);
    chk("count on reserved clock", a, b);
    wr(CTM_ADDR_C0, 8'h10);
    wr(CTM_ADDR_C0, 8'h18);
    rd(CTM_ADDR_CNT, c);
    rng("count cleared by on", 0, 6, c);
    repeat (1030) @(posedge pclk);
    rd(CTM_ADDR_CNT, c);
    rng("count after overflow", 0, 40, c);
    $display("test pause and on done");
  endtask

  task automatic t_period;
    int n;
    logic [31:0] q;
    wr(CTM_ADDR_C0, 8'h11);
    wr(CTM_ADDR_AL, 8'h7F);
    wr(CTM_ADDR_AH, 8'h02);
    wr(CTM_ADDR_C1, 8'hCC);
    wr(CTM_ADDR_STAT, 8'h03);
    wr(CTM_ADDR_C0, 8'h19);
    wait_flag(1'b1, 300, n);
    rng("cycles to p match", 124, 134, n);
    chk("a flag on low bits only", 32'h0, {31'h0, match_a_flag});
    chk("pins in timer mode", 32'h0, {30'h0, timer_output_pin_0, timer_output_pin_1});
    rd(CTM_ADDR_STAT, q);
    chk("status flags", 32'h2, q & 32'h3);
    // timer mode leaves the pins to other functions
    pin_enable <= 2'b00;
    repeat (2) @(posedge pclk);
    chk("pins released in timer mode", 32'h0, {30'h0, timer_output_pin_0, timer_output_pin_1});
    pin_enable <= 2'b11;
    $display("test period done");
  endtask

  task automatic t_compare;
    logic [7:0] c1v[5] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h25};
    logic aft[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int n;
    wr(CTM_ADDR_AL, 8'h10);
    wr(CTM_ADDR_AH, 8'h00);
    for (int i = 0; i < 5; i++) begin
      // module off before the mode and action change
      wr(CTM_ADDR_C0, 8'h10);
      wr(CTM_ADDR_STAT, 8'h03);
      wr(CTM_ADDR_C1, c1v[i]);
      wr(CTM_ADDR_C0, 8'h18);
      repeat (4) @(posedge pclk);
      chk("pin at start", 32'h1, {31'h0, timer_output_pin_0});
      wait_flag(1'b0, 40, n);
      repeat (2) @(posedge pclk);
      chk("pins after a match", {30'h0, aft[i], aft[i]}, {30'h0, timer_output_pin_0, timer_output_pin_1});
      chk("p flag with clear on a", 32'h0, {31'h0, match_p_flag});
    end
    $display("test compare done");
  endtask

  task automatic t_pwm;
    logic [7:0] c1v[8] = '{8'hA8, 8'hA9, 8'hA8, 8'h88, 8'h98, 8'h9C, 8'hAA, 8'hA0};
    logic [9:0] av[8] = '{10'd32, 10'd32, 10'd200, 10'd32, 10'd32, 10'd32, 10'd256, 10'd32};
    int exp[8] = '{64, 64, 256, 0, 256, 0, 128, 192};
    int hi;
    logic same;
    for (int i = 0; i < 8; i++) begin
      // pin action only changed while off
      wr(CTM_ADDR_C0, 8'h11);
      wr(CTM_ADDR_C1, c1v[i]);
      wr(CTM_ADDR_AL, av[i][7:0]);
      wr(CTM_ADDR_AH, {6'h00, av[i][9:8]});
      wr(CTM_ADDR_C0, 8'h19);
      repeat (300) @(posedge pclk);
      hi = 0;
      same = 1'b1;
      repeat (256) begin
        @(posedge pclk);
        if (timer_output_pin_0 === 1'b1) hi++;
        if (timer_output_pin_0 !== timer_output_pin_1) same = 1'b0;
      end
      rng("pwm high cycles", (exp[i] > 4) ? exp[i] - 4 : 0, (exp[i] < 252) ? exp[i] + 4 : 256, hi);
      chk("pwm pins equal", 32'h1, {31'h0, same});
    end
    $display("test pwm done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clock();
    t_pause();
    t_period();
    t_compare();
    t_pwm();
    close_out();
  end
endmodule // compact_timer_module_control_test
